// ### design/ftc_consts.vh
// Shared constants of the front-end trigger control block.
// Included by the control top and its buffer module; definitions only.
`ifndef FTC_CONSTS_VH
`define FTC_CONSTS_VH

// Array sizes
`define FTC_NCH 128
`define FTC_NSEC 8
`define FTC_LAT_AW 8
`define FTC_TRIG_DEPTH 128
`define FTC_TRIG_AW 7
`define FTC_TRIG_W 148
`define FTC_STAGE_DEPTH 8
`define FTC_STAGE_AW 3
`define FTC_WORD_W 16
`define FTC_FRAME_W 176
`define FTC_FRAME_WORDS 4'hb

// Fast command patterns, leading bit always set
`define FTC_CMD_L1A 3'h4
`define FTC_CMD_CAL 3'h7
`define FTC_CMD_RSY 3'h6
`define FTC_CMD_BC0 3'h5

// Sector modes
`define FTC_MODE_ONE 3'h1
`define FTC_MODE_FOUR 3'h2
`define FTC_MODE_EIGHT 3'h3

// Hard-wired sleep defaults and counter limits
`define FTC_DEF_RUN 1'h0
`define FTC_DEF_TRIG 3'h0
`define FTC_DEF_LAT 8'h80
`define FTC_UPSET_RST 8'h00
`define FTC_UPSET_MAX 8'hff

// Triplicated control word: use_regs, run, trig[2:0], lat[7:0], dec_cnt[1:0], dec_bit
`define FTC_CTW 16
`define FTC_CT_USE 15
`define FTC_CT_RUN 14
`define FTC_CT_TRIG 13:11
`define FTC_CT_LAT 10:3
`define FTC_CT_DCNT 2:1
`define FTC_CT_DBIT 0

`endif

// ### design/ftc_fifo.v
// Synchronous FIFO with a registered output stage and a flush.
// Assumes one clock; flush_i comes from logic on the same clock.
`timescale 1ns/1ps
`include "ftc_consts.vh"

module ftc_fifo #(
	parameter W = 16,
	parameter D = 8,
	parameter AW = 3
) (
	// Clock and reset
	input wire clk_i,
	input wire nrst_i,
	input wire flush_i,
	// Fill side
	input wire in_valid_i,
	output wire in_ready_o,
	input wire [W-1:0] in_data_i,
	// Drain side
	output wire out_valid_o,
	input wire out_ready_i,
	output wire [W-1:0] out_data_o
);

	localparam [AW:0] DFULL = D;

	reg [W-1:0] mem [0:D-1];
	reg [AW-1:0] wp_ff;
	reg [AW-1:0] rp_ff;
	reg [AW:0] cnt_ff;
	reg out_v_ff;
	reg [W-1:0] out_data_ff;
	wire wr;
	wire take;

	// Handshakes; head moves into the output stage when it is free
	assign in_ready_o = (cnt_ff != DFULL);
	assign wr = in_valid_i & in_ready_o;
	assign take = (cnt_ff != {(AW+1){1'b0}}) & (~out_v_ff | out_ready_i);
	assign out_valid_o = out_v_ff;
	assign out_data_o = out_data_ff;

	// Storage array, no reset
	always @(posedge clk_i)
	begin
		if (wr)
			mem[wp_ff] <= in_data_i;
	end

	// Pointers, fill count and output register
	always @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			wp_ff <= {AW{1'b0}};
			rp_ff <= {AW{1'b0}};
			cnt_ff <= {(AW+1){1'b0}};
			out_v_ff <= 1'b0;
			out_data_ff <= {W{1'b0}};
		end
		else if (flush_i)
		begin
			wp_ff <= {AW{1'b0}};
			rp_ff <= {AW{1'b0}};
			cnt_ff <= {(AW+1){1'b0}};
			out_v_ff <= 1'b0;
		end
		else
		begin
			if (wr)
				wp_ff <= wp_ff + 1'b1;
			if (take)
			begin
				out_data_ff <= mem[rp_ff];
				rp_ff <= rp_ff + 1'b1;
			end
			out_v_ff <= take | (out_v_ff & ~out_ready_i);
			cnt_ff <= cnt_ff + {{AW{1'b0}}, wr} - {{AW{1'b0}}, take};
		end
	end

endmodule

// ### design/ftc_frontend_trigger_control.v
// Front-end trigger control: fast command decoder, sector fast-OR,
// crossing and event counters, latency and trigger buffers, formatter.
// Assumes hit and control pins are asynchronous and get synchronised here;
// I2C register values and the serializer ready are on sys_clk_i.
`timescale 1ns/1ps
`include "ftc_consts.vh"

module ftc_frontend_trigger_control (
	// Clock and power-on reset
	input wire sys_clk_i,
	input wire nrst_i,
	// Asynchronous pins
	input wire hard_reset_n_i,
	input wire clear_n_i,
	input wire fast_command_line_i,
	input wire [`FTC_NCH-1:0] hit_i,
	// Scan test pins
	input wire scan_clk_i,
	input wire scan_en_i,
	input wire scan_in_i,
	output wire scan_out_o,
	// Register values from the I2C port
	input wire cfg_load_i,
	input wire cfg_run_i,
	input wire [2:0] cfg_trig_mode_i,
	input wire [7:0] cfg_latency_i,
	input wire [15:0] chip_id_i,
	// Fast outputs
	output reg [`FTC_NSEC-1:0] sector_outputs_o,
	output reg [`FTC_NSEC-1:0] sector_enable_o,
	// Decoded command strobes and counters
	output wire level1_accept_o,
	output wire calibration_strobe_cmd_o,
	output wire realign_command_o,
	output wire orbit_zero_marker_o,
	output wire [11:0] crossing_count_o,
	output wire [7:0] event_count_o,
	output wire [7:0] upset_tally_count_o,
	// Serializer stream
	output wire [`FTC_WORD_W-1:0] ser_data_o,
	output wire ser_valid_o,
	input wire ser_ready_i
);

	reg [5:0] pin_meta_ff;
	reg [5:0] pin_sync_ff;
	reg [`FTC_NCH-1:0] hit_meta_ff;
	reg [`FTC_NCH-1:0] hit_sync_ff;
	reg [`FTC_NCH-1:0] hit_prev_ff;
	reg scan_prev_ff;
	reg [`FTC_CTW-1:0] tmr_a_ff;
	reg [`FTC_CTW-1:0] tmr_b_ff;
	reg [`FTC_CTW-1:0] tmr_c_ff;
	reg [`FTC_CTW-1:0] nxt_tmr;
	reg l1a_ff;
	reg cal_ff;
	reg rsy_ff;
	reg bc0_ff;
	reg [11:0] bcn_ff;
	reg [7:0] ec_ff;
	reg [7:0] upset_ff;
	reg [`FTC_NCH-1:0] lat_mem [0:(1<<`FTC_LAT_AW)-1];
	reg [`FTC_LAT_AW-1:0] wptr_ff;
	reg [`FTC_NCH-1:0] slot_ff;
	reg [19:0] hdr_ff;
	reg push_ff;
	reg [`FTC_FRAME_W-1:0] frame_ff;
	reg [3:0] fcnt_ff;
	reg [`FTC_NSEC-1:0] nxt_sec;
	reg [`FTC_NSEC-1:0] nxt_sen;

	wire hrst_n;
	wire clr_n;
	wire cmd_bit;
	wire scan_shift;
	wire [`FTC_NCH-1:0] hit_pulse;
	wire [`FTC_CTW-1:0] ctl;
	wire mismatch;
	wire run;
	wire [2:0] trig_mode;
	wire [7:0] latency;
	wire cmd_done;
	wire [2:0] cmd;
	wire [`FTC_NSEC-1:0] or16;
	wire [3:0] or32;
	wire [1:0] or64;
	wire or128;
	wire tb_in_ready;
	wire tb_valid;
	wire tb_pop;
	wire [`FTC_TRIG_W-1:0] tb_data;
	wire st_in_ready;
	wire st_push;

	// Two-stage synchronisers for pins: hard reset, clear, command, scan
	always @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			pin_meta_ff <= 6'h03;
			pin_sync_ff <= 6'h03;
			hit_meta_ff <= {`FTC_NCH{1'b0}};
			hit_sync_ff <= {`FTC_NCH{1'b0}};
			hit_prev_ff <= {`FTC_NCH{1'b0}};
			scan_prev_ff <= 1'b0;
		end
		else
		begin
			pin_meta_ff <= {scan_in_i, scan_en_i, scan_clk_i,
				fast_command_line_i, clear_n_i, hard_reset_n_i};
			pin_sync_ff <= pin_meta_ff;
			hit_meta_ff <= hit_i;
			hit_sync_ff <= hit_meta_ff;
			hit_prev_ff <= hit_sync_ff;
			scan_prev_ff <= pin_sync_ff[3];
		end
	end

	assign hrst_n = pin_sync_ff[0];
	assign clr_n = pin_sync_ff[1];
	assign cmd_bit = pin_sync_ff[2];
	// Scan shifts only on test clock edges, never on the master clock rate
	assign scan_shift = pin_sync_ff[4] & pin_sync_ff[3] & ~scan_prev_ff;
	// Monostable: one cycle per comparator crossing
	assign hit_pulse = hit_sync_ff & ~hit_prev_ff;

	// Majority vote and mismatch flag over the three copies
	assign ctl = (tmr_a_ff & tmr_b_ff) | (tmr_b_ff & tmr_c_ff) | (tmr_a_ff & tmr_c_ff);
	assign mismatch = |((tmr_a_ff ^ tmr_b_ff) | (tmr_b_ff ^ tmr_c_ff));

	// Function muxes pick hard-wired defaults until registers are loaded
	assign run = ctl[`FTC_CT_USE] ? ctl[`FTC_CT_RUN] : `FTC_DEF_RUN;
	assign trig_mode = ctl[`FTC_CT_USE] ? ctl[`FTC_CT_TRIG] : `FTC_DEF_TRIG;
	assign latency = ctl[`FTC_CT_USE] ? ctl[`FTC_CT_LAT] : `FTC_DEF_LAT;

	// Third symbol bit completes a command
	assign cmd_done = (ctl[`FTC_CT_DCNT] == 2'h2);
	assign cmd = {1'b1, ctl[`FTC_CT_DBIT], cmd_bit};

	// Next control word: reset defaults, scan, register load, decoder
	always @*
	begin
		nxt_tmr = ctl;
		if (!hrst_n)
		begin
			nxt_tmr = {1'b0, `FTC_DEF_RUN, `FTC_DEF_TRIG, `FTC_DEF_LAT, 3'h0};
		end
		else if (scan_shift)
		begin
			nxt_tmr = {ctl[`FTC_CTW-2:0], pin_sync_ff[5]};
		end
		else
		begin
			if (cfg_load_i)
			begin
				nxt_tmr[`FTC_CT_USE] = 1'b1;
				nxt_tmr[`FTC_CT_RUN] = cfg_run_i;
				nxt_tmr[`FTC_CT_TRIG] = cfg_trig_mode_i;
				nxt_tmr[`FTC_CT_LAT] = cfg_latency_i;
			end
			// Decoder idles until a leading 1, then takes two bits
			case (ctl[`FTC_CT_DCNT])
				2'h0:
				begin
					if (cmd_bit)
						nxt_tmr[`FTC_CT_DCNT] = 2'h1;
				end
				2'h1:
				begin
					nxt_tmr[`FTC_CT_DCNT] = 2'h2;
					nxt_tmr[`FTC_CT_DBIT] = cmd_bit;
				end
				default:
				begin
					nxt_tmr[`FTC_CT_DCNT] = 2'h0;
					nxt_tmr[`FTC_CT_DBIT] = 1'b0;
				end
			endcase
			// Realign restarts the decoder, keeps register values
			if (rsy_ff)
				nxt_tmr[2:0] = 3'h0;
		end
	end

	// Three copies of the control word, power-on to sleep defaults
	always @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			tmr_a_ff <= {1'b0, `FTC_DEF_RUN, `FTC_DEF_TRIG, `FTC_DEF_LAT, 3'h0};
			tmr_b_ff <= {1'b0, `FTC_DEF_RUN, `FTC_DEF_TRIG, `FTC_DEF_LAT, 3'h0};
			tmr_c_ff <= {1'b0, `FTC_DEF_RUN, `FTC_DEF_TRIG, `FTC_DEF_LAT, 3'h0};
		end
		else
		begin
			tmr_a_ff <= nxt_tmr;
			tmr_b_ff <= nxt_tmr;
			tmr_c_ff <= nxt_tmr;
		end
	end

	// Registered command strobes, one cycle each
	always @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			l1a_ff <= 1'b0;
			cal_ff <= 1'b0;
			rsy_ff <= 1'b0;
			bc0_ff <= 1'b0;
		end
		else
		begin
			l1a_ff <= hrst_n & cmd_done & (cmd == `FTC_CMD_L1A);
			cal_ff <= hrst_n & cmd_done & (cmd == `FTC_CMD_CAL);
			rsy_ff <= hrst_n & cmd_done & (cmd == `FTC_CMD_RSY);
			bc0_ff <= hrst_n & cmd_done & (cmd == `FTC_CMD_BC0);
		end
	end

	assign level1_accept_o = l1a_ff;
	assign calibration_strobe_cmd_o = cal_ff;
	assign realign_command_o = rsy_ff;
	assign orbit_zero_marker_o = bc0_ff;

	// Crossing, event and upset counters
	always @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			bcn_ff <= 12'h000;
			ec_ff <= 8'h00;
			upset_ff <= `FTC_UPSET_RST;
		end
		else
		begin
			if (bc0_ff | rsy_ff)
				bcn_ff <= 12'h000;
			else
				bcn_ff <= bcn_ff + 1'b1;
			if (bc0_ff | rsy_ff | ~clr_n)
				ec_ff <= 8'h00;
			else if (l1a_ff)
				ec_ff <= ec_ff + 1'b1;
			if (!clr_n)
				upset_ff <= `FTC_UPSET_RST;
			else if (mismatch && upset_ff != `FTC_UPSET_MAX)
				upset_ff <= upset_ff + 1'b1;
		end
	end

	assign crossing_count_o = bcn_ff;
	assign event_count_o = ec_ff;
	assign upset_tally_count_o = upset_ff;

	// Latency ring: every cycle one slot of all channels is written
	always @(posedge sys_clk_i)
	begin
		lat_mem[wptr_ff] <= hit_pulse & {`FTC_NCH{run}};
		if (l1a_ff)
			slot_ff <= lat_mem[wptr_ff - latency];
	end

	// Write pointer and trigger capture with headers
	always @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			wptr_ff <= {`FTC_LAT_AW{1'b0}};
			hdr_ff <= 20'h0_0000;
			push_ff <= 1'b0;
		end
		else if (rsy_ff)
		begin
			wptr_ff <= {`FTC_LAT_AW{1'b0}};
			push_ff <= 1'b0;
		end
		else
		begin
			wptr_ff <= wptr_ff + 1'b1;
			push_ff <= l1a_ff & run;
			if (l1a_ff)
				hdr_ff <= {bcn_ff, ec_ff};
		end
	end

	// Trigger buffer; an accept arriving while it is full is dropped
	ftc_fifo #(
		.W(`FTC_TRIG_W),
		.D(`FTC_TRIG_DEPTH),
		.AW(`FTC_TRIG_AW)
	) u_trigger_buffer (
		.clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.flush_i(rsy_ff),
		.in_valid_i(push_ff),
		.in_ready_o(tb_in_ready),
		.in_data_i({hdr_ff, slot_ff}),
		.out_valid_o(tb_valid),
		.out_ready_i(tb_pop),
		.out_data_o(tb_data)
	);

	// Formatter takes a new event as soon as the previous one is sent
	assign tb_pop = tb_valid & (fcnt_ff == 4'h0);
	assign st_push = (fcnt_ff != 4'h0);

	// Frame: identifier, crossing, event count, then channel words
	always @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			frame_ff <= {`FTC_FRAME_W{1'b0}};
			fcnt_ff <= 4'h0;
		end
		else if (rsy_ff)
		begin
			fcnt_ff <= 4'h0;
		end
		else if (tb_pop)
		begin
			frame_ff <= {chip_id_i, 4'h0, tb_data[147:136],
				8'h00, tb_data[135:128], tb_data[127:0]};
			fcnt_ff <= `FTC_FRAME_WORDS;
		end
		else if (st_push && st_in_ready)
		begin
			frame_ff <= {frame_ff[`FTC_FRAME_W-`FTC_WORD_W-1:0], {`FTC_WORD_W{1'b0}}};
			fcnt_ff <= fcnt_ff - 1'b1;
		end
	end

	// Staging FIFO toward the serializer; its stall holds the formatter
	ftc_fifo #(
		.W(`FTC_WORD_W),
		.D(`FTC_STAGE_DEPTH),
		.AW(`FTC_STAGE_AW)
	) u_stage (
		.clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.flush_i(rsy_ff),
		.in_valid_i(st_push),
		.in_ready_o(st_in_ready),
		.in_data_i(frame_ff[`FTC_FRAME_W-1:`FTC_FRAME_W-`FTC_WORD_W]),
		.out_valid_o(ser_valid_o),
		.out_ready_i(ser_ready_i),
		.out_data_o(ser_data_o)
	);

	assign scan_out_o = ctl[`FTC_CTW-1];

	// Fast-OR trees over groups of 16, 32, 64 and all channels
	genvar gi;
	generate
		for (gi = 0; gi < `FTC_NSEC; gi = gi + 1)
		begin : g_or16
			assign or16[gi] = |hit_pulse[gi*16 +: 16];
		end
	endgenerate

	assign or32 = {or16[7] | or16[6], or16[5] | or16[4], or16[3] | or16[2], or16[1] | or16[0]};
	assign or64 = {or32[3] | or32[2], or32[1] | or32[0]};
	assign or128 = or64[1] | or64[0];

	// Sector mapping per mode; unused drivers disabled
	always @*
	begin
		nxt_sec = 8'h00;
		nxt_sen = 8'h00;
		if (trig_mode[2])
		begin
			nxt_sec = {6'h00, or64};
			nxt_sen = 8'h03;
		end
		else
		begin
			case (trig_mode[1:0])
				2'h1:
				begin
					nxt_sec = {7'h00, or128};
					nxt_sen = 8'h01;
				end
				2'h2:
				begin
					nxt_sec = {4'h0, or32};
					nxt_sen = 8'h0f;
				end
				2'h3:
				begin
					nxt_sec = or16;
					nxt_sen = 8'hff;
				end
				default:
				begin
					nxt_sec = 8'h00;
					nxt_sen = 8'h00;
				end
			endcase
		end
		if (!run)
		begin
			nxt_sec = 8'h00;
			nxt_sen = 8'h00;
		end
	end

	// Registered sector outputs and driver enables
	always @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			sector_outputs_o <= 8'h00;
			sector_enable_o <= 8'h00;
		end
		else
		begin
			sector_outputs_o <= nxt_sec & nxt_sen;
			sector_enable_o <= nxt_sen;
		end
	end

endmodule

// ### sim/ftc_ser_sink.sv
// Serializer model: takes stream words while ready, stalls on request.
// Assumes the block's stream port on the same rising clock edge.
`timescale 1ns/1ps
module ftc_ser_sink (
	// Clock and reset
	input wire clk_i,
	input wire nrst_i,
	// Bench control
	input wire stall_i,
	// Stream from the block
	input wire [15:0] data_i,
	input wire valid_i,
	output logic ready_o
);
	logic [15:0] words [0:63];
	integer count;
	// Ready follows the settled stall request as an update on the rising edge
	initial ready_o = 1'b0;
	always @(posedge clk_i)
		ready_o <= !stall_i;
	// Keep the first 64 words taken at an edge with valid and ready
	always @(posedge clk_i or negedge nrst_i)
		if (!nrst_i)
			count <= 0;
		else if (valid_i && ready_o && count < 64)
		begin
			words[count] <= data_i;
			count <= count + 1;
		end
endmodule

// ### sim/ftc_frontend_trigger_control_checker.sv
// Checker for strobes, counters, sector masking and the stream port.
// Assumes one clock domain and the async active-low power-on reset.
`timescale 1ns/1ps
module ftc_checker (
	// Clock and reset
	input logic sys_clk_i,
	input logic nrst_i,
	// Strobes and counters
	input logic level1_accept_o,
	input logic calibration_strobe_cmd_o,
	input logic realign_command_o,
	input logic orbit_zero_marker_o,
	input logic [11:0] crossing_count_o,
	input logic [7:0] event_count_o,
	input logic [7:0] upset_tally_count_o,
	// Sectors and stream
	input logic [7:0] sector_outputs_o,
	input logic [7:0] sector_enable_o,
	input logic [15:0] ser_data_o,
	input logic ser_valid_o,
	input logic ser_ready_i
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);
	// All four command strobes side by side
	wire [3:0] strb = {level1_accept_o, calibration_strobe_cmd_o,
		realign_command_o, orbit_zero_marker_o};
	a_strobe_onehot: assert property ($onehot0(strb))
		else $error("two command strobes at once");
	a_strobe_spacing: assert property (strb != 4'h0 |=> strb == 4'h0 ##1 strb == 4'h0)
		else $error("strobes closer than one symbol");
	a_crossing_step: assert property (!orbit_zero_marker_o && !realign_command_o
		|=> crossing_count_o == $past(crossing_count_o) + 12'h001)
		else $error("crossing count did not step");
	a_marker_clear: assert property (orbit_zero_marker_o || realign_command_o
		|=> crossing_count_o == 12'h000 && event_count_o == 8'h00)
		else $error("counters not cleared");
	a_event_step: assert property (level1_accept_o
		|=> event_count_o == $past(event_count_o) + 8'h01)
		else $error("event count did not step");
	a_upset_step: assert property (upset_tally_count_o != $past(upset_tally_count_o)
		|-> upset_tally_count_o == 8'h00 || ($past(upset_tally_count_o) != 8'hff
		&& upset_tally_count_o == $past(upset_tally_count_o) + 8'h01))
		else $error("upset count jumped");
	a_sector_mask: assert property ((sector_outputs_o & ~sector_enable_o) == 8'h00)
		else $error("disabled sector driven");
	a_stream_hold: assert property (ser_valid_o && !ser_ready_i && !realign_command_o
		&& !$past(realign_command_o) |=> ser_valid_o && $stable(ser_data_o))
		else $error("stream word dropped while stalled");
endmodule
bind ftc_frontend_trigger_control ftc_checker u_chk (.sys_clk_i, .nrst_i,
	.level1_accept_o, .calibration_strobe_cmd_o, .realign_command_o,
	.orbit_zero_marker_o, .crossing_count_o, .event_count_o, .upset_tally_count_o,
	.sector_outputs_o, .sector_enable_o, .ser_data_o, .ser_valid_o, .ser_ready_i);

// ### sim/ftc_frontend_trigger_control_tb_top.sv
// Self-checking bench: sectors, commands, counters, stream and resets.
// Assumes the checker is bound and the serializer model takes the stream.
`timescale 1ns/1ps
`include "ftc_consts.vh"
`define CHK(a, e, m) begin check_count++; if ((a) !== (e)) begin miscompares++; \
	$display("CHECK FAILED t=%0t %s", $time, m); end end
module ftc_frontend_trigger_control_tb_top;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic hard_n = 1'b1;
	logic clr_n = 1'b1;
	logic fcl = 1'b0;
	logic [127:0] hit = 128'h0;
	logic load_p = 1'b0;
	logic run = 1'b0;
	logic [2:0] mode = 3'h0;
	logic stall = 1'b0;
	logic sclk = 1'b0;
	logic scan_en = 1'b0;
	wire [7:0] sec, sen, evc, ups;
	wire l1a, cal, rsy, bc0, so, sv, sr;
	wire [11:0] crossing_count;
	wire [15:0] sd;
	integer miscompares = 0;
	integer check_count = 0;
	integer i, k;
	logic [3:0] got;
	logic [7:0] seen;
	logic [11:0] bc_at;
	localparam logic [15:0] CHIP_ID = 16'h5a3c; // Arbitrary identifier
	logic [7:0] en_tab [0:4] = '{8'h00, 8'h01, 8'h0f, 8'hff, 8'h03};
	logic [2:0] hm_tab [0:2] = '{3'h3, 3'h3, 3'h2};
	integer hc_tab [0:2] = '{20, 127, 40};
	logic [7:0] hs_tab [0:2] = '{8'h02, 8'h80, 8'h02};
	logic [1:0] cb_tab [0:3] = '{2'h2, 2'h1, 2'h3, 2'h0};
	logic [3:0] cs_tab [0:3] = '{4'h2, 4'h1, 4'h4, 4'h8};
	ftc_frontend_trigger_control u_dut (.sys_clk_i(clk), .nrst_i(nrst),
		.hard_reset_n_i(hard_n), .clear_n_i(clr_n), .fast_command_line_i(fcl),
		.hit_i(hit), .scan_clk_i(sclk), .scan_en_i(scan_en), .scan_in_i(1'b0),
		.scan_out_o(so), .cfg_load_i(load_p), .cfg_run_i(run), .cfg_trig_mode_i(mode),
		.cfg_latency_i(8'h10), .chip_id_i(CHIP_ID), .sector_outputs_o(sec),
		.sector_enable_o(sen), .level1_accept_o(l1a), .calibration_strobe_cmd_o(cal),
		.realign_command_o(rsy), .orbit_zero_marker_o(bc0), .crossing_count_o(crossing_count),
		.event_count_o(evc), .upset_tally_count_o(ups), .ser_data_o(sd),
		.ser_valid_o(sv), .ser_ready_i(sr));
	ftc_ser_sink u_sink (.clk_i(clk), .nrst_i(nrst), .stall_i(stall), .data_i(sd),
		.valid_i(sv), .ready_o(sr));
	// Master clock, 100 ns period
	initial
		forever #50 clk = ~clk;
	task cyc(input integer n);
		repeat (n) @(negedge clk);
	endtask
	// One symbol: leading 1, then two bits, MSB first
	task send(input [1:0] b);
		fcl = 1'b1;
		cyc(1);
		fcl = b[1];
		cyc(1);
		fcl = b[0];
		cyc(1);
	endtask
	// Idle the line and wait a bounded time for a strobe
	task watch;
		fcl = 1'b0;
		got = 4'h0;
		for (k = 0; k < 8 && got == 4'h0; k++)
		begin
			cyc(1);
			got = {l1a, cal, rsy, bc0};
			bc_at = crossing_count;
		end
	endtask
	task load(input r, input [2:0] m);
		run = r;
		mode = m;
		load_p = 1'b1;
		cyc(1);
		load_p = 1'b0;
		cyc(2);
	endtask
	// One slow test clock period, long enough for the pin synchronisers
	task sclk_pulse;
		sclk = 1'b1;
		cyc(3);
		sclk = 1'b0;
		cyc(3);
	endtask
	task wait_words(input integer n);
		for (k = 0; k < 200 && u_sink.count < n; k++)
			cyc(1);
	endtask
	task final_report;
		$display("Comparisons %0d, mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		cyc(2);
		nrst = 1'b1;
		cyc(2);
		`CHK(sen, 8'h00, "enables after reset")
		`CHK(so, 1'b0, "mux select after reset")
		`CHK(ups, 8'h00, "upset reset value")
		for (i = 0; i < 5; i++)
		begin
			load(1'b1, i[2:0]);
			`CHK(sen, en_tab[i], "sector enables")
		end
		for (i = 0; i < 3; i++)
		begin
			load(1'b1, hm_tab[i]);
			hit[hc_tab[i]] = 1'b1;
			seen = 8'h00;
			repeat (8)
			begin
				cyc(1);
				seen = seen | sec;
			end
			hit = 128'h0;
			`CHK(seen, hs_tab[i], "sector fast output")
		end
		for (i = 0; i < 4; i++)
		begin
			send(cb_tab[i]);
			watch;
			`CHK(got, cs_tab[i], "command strobe")
		end
		wait_words(11);
		`CHK(evc, 8'h01, "event count")
		`CHK(u_sink.count, 11, "words per event")
		`CHK(u_sink.words[0], CHIP_ID, "id header")
		`CHK(u_sink.words[1], {4'h0, bc_at}, "crossing header")
		`CHK(u_sink.words[2], 16'h0000, "event header")
		stall = 1'b1;
		send(2'h0);
		send(2'h0);
		send(2'h0);
		fcl = 1'b0;
		cyc(40);
		`CHK(u_sink.count, 11, "stalled stream")
		`CHK(sv, 1'b1, "word waiting")
		stall = 1'b0;
		wait_words(44);
		for (i = 1; i < 4; i++)
			`CHK(u_sink.words[11 * i + 2], {8'h00, i[7:0]}, "event numbers")
		`CHK(evc, 8'h04, "event count")
		stall = 1'b1;
		send(2'h0);
		fcl = 1'b0;
		cyc(6);
		send(2'h2);
		watch;
		stall = 1'b0;
		cyc(30);
		`CHK(u_sink.count, 44, "realign drops pending")
		`CHK(evc, 8'h00, "realign clears events")
		`CHK(sen, 8'h0f, "realign keeps settings")
		load(1'b0, 3'h3);
		send(2'h0);
		watch;
		cyc(30);
		`CHK(u_sink.count, 44, "nothing stored asleep")
		// One copy disagrees for a cycle; the vote repairs it at the next edge
		u_dut.tmr_b_ff[3] = ~u_dut.tmr_b_ff[3];
		cyc(2);
		`CHK(ups, 8'h01, "upset counted")
		repeat (300)
		begin
			u_dut.tmr_b_ff[3] = ~u_dut.tmr_b_ff[3];
			cyc(1);
		end
		cyc(2);
		`CHK(ups, 8'hff, "upset saturates")
		clr_n = 1'b0;
		cyc(3);
		clr_n = 1'b1;
		cyc(4);
		`CHK(evc, 8'h00, "clear resets events")
		`CHK(ups, 8'h00, "clear resets upsets")
		load(1'b1, 3'h3);
		`CHK(so, 1'b1, "registers selected")
		hard_n = 1'b0;
		cyc(5);
		`CHK(sen, 8'h00, "hard reset defaults")
		`CHK(so, 1'b0, "defaults selected")
		hard_n = 1'b1;
		cyc(4);
		`CHK(sen, 8'h00, "defaults kept")
		// Sleep word has its latency MSB at bit 10; five shifts bring it out
		repeat (5) sclk_pulse;
		`CHK(so, 1'b0, "no shift without enable")
		scan_en = 1'b1;
		repeat (4) sclk_pulse;
		`CHK(so, 1'b0, "four shifts")
		sclk_pulse;
		`CHK(so, 1'b1, "scan chain shifts")
		scan_en = 1'b0;
		// Let the crossing counter pass its wrap under the checker
		cyc(4100);
		final_report;
	end
	// Watchdog well beyond the expected run
	initial
	begin
		#3000000;
		miscompares++;
		final_report;
	end
endmodule
